// ### shared/asp_consts.svh
// Purpose: offsets, field positions, reset values and divider masks
// Assumes: register index = byte address / 4
// Notes:   definitions only
`ifndef ASP_CONSTS_SVH
`define ASP_CONSTS_SVH

// ==========================================================
// register indices
`define ASP_IDX_MODE  3'h0
`define ASP_IDX_ERR   3'h1
`define ASP_IDX_BRG   3'h2
`define ASP_IDX_TXS   3'h3
`define ASP_IDX_RXB   3'h4
`define ASP_IDX_STAT  3'h5

// ==========================================================
// reset values
`define ASP_MODE_RST  8'h01
`define ASP_BRG_RST   8'h08
`define ASP_DATA_RST  8'h00

// ==========================================================
// error status bit positions
`define ASP_ERR_PE    2
`define ASP_ERR_FE    1
`define ASP_ERR_OVE   0

// ==========================================================
// prescaler terminal masks for base clock divide by 2, 8, 32
`define ASP_DIV2_MASK  5'h01
`define ASP_DIV8_MASK  5'h07
`define ASP_DIV32_MASK 5'h1F

`endif

// ### shared/asp_pkg.sv
// Purpose: types shared by the serial port files
// Assumes: nothing
// Notes:   field layouts mirror the register bit order
package asp_pkg;

  // ==========================================================
  // parity selection, two-bit field of the mode register
  typedef enum logic [1:0] {
    ASP_PAR_NONE = 2'h0,
    ASP_PAR_ZERO = 2'h1,
    ASP_PAR_ODD  = 2'h2,
    ASP_PAR_EVEN = 2'h3
  } asp_parity_type;

  // port_mode_register layout, bit 7 down to bit 0
  typedef struct packed {
    logic           power;
    logic           txen;
    logic           rxen;
    asp_parity_type parity;
    logic           len8;
    logic           stop2;
    logic           fixed1;
  } asp_mode_type;

  // baud_generator_control layout
  typedef struct packed {
    logic [1:0] clk_sel;
    logic       rsvd;
    logic [4:0] k;
  } asp_brg_type;

  // reception_error_status low bits
  typedef struct packed {
    logic pe;
    logic fe;
    logic ove;
  } asp_err_type;

  // ==========================================================
  // state machines
  typedef enum logic {TX_IDLE, TX_SEND} asp_tx_state_type;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS} asp_rx_state_type;

endpackage : asp_pkg

// ### rtl/asp_brg.sv
// Purpose: one 5-bit baud counter, half-bit pulse every k base ticks
// Assumes: tick_i is a one-cycle enable at the base clock rate
// Notes:   held at zero while clr_i is high
`timescale 1ns/1ps
module asp_brg #(
  parameter int CNT_W = 5
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             clr_i,
  input  wire logic             tick_i,
  input  wire logic [CNT_W-1:0] k_i,
  output logic                  half_o,
  output logic      [CNT_W-1:0] cnt_o
);

  // ==========================================================
  // counter; >= guards against k lowered mid-count
  always_ff @(posedge clk_i) begin
    if (rst_i || clr_i) begin
      cnt_o  <= '0;
      half_o <= 1'b0;
    end else begin
      half_o <= 1'b0;
      if (tick_i) begin
        if (cnt_o >= k_i - CNT_W'(1)) begin
          cnt_o  <= '0;
          half_o <= 1'b1;
        end else begin
          cnt_o <= cnt_o + CNT_W'(1);
        end
      end
    end
  end

endmodule : asp_brg

// ### rtl/asp_top.sv
// Purpose: asynchronous serial port with baud generator, Wishbone slave
// Assumes: REF_CLK_I is the peripheral clock, RST_I synchronous
// Notes:   base clock is an enable pulse, never a real clock
// Function
// R1 - no-parity format: no parity bit sent, none expected, no parity error
// R2 - transmit enabled by power then transmit enable; data write starts frame
// R3 - frame is start bit, data LSB first, parity, stop bits
// R4 - transmit-done pulse right after the last stop bit
// R5 - transmitter idles at stop level until the next data write
// R6 - software writes no new character before transmit-done
// R7 - receiver samples only after power then receive enable are set
// R8 - falling edge, count k, resample; low means valid start
// R9 - shift at baud rate; stop bit copies to buffer unless overrun
// R10 - parity error does not abort; receive pulse at stop bit
// R11 - receiver checks exactly one stop bit
// R12 - parity, framing, overrun detected; receive pulse on any error
// R13 - reading error status returns flags and clears them
// R14 - parity mismatch, missing stop bit, unread buffer set the flags
// R15 - software reads error status then buffer after an error
// R16 - two-sample match filter on the base clock on receive input
// R17 - separate 5-bit counters for transmit and receive
// R18 - base clock held low while power is off
// R19 - transmit counter zero unless power and transmit enable; cleared on write
// R20 - receive counter cleared when disabled, runs only during a frame
// R21 - baud equals base clock over 2k, k in bits 4..0
// R22 - select 00 timer output, 01 divide 2, 10 divide 8
// R23 - even parity makes ones even, odd parity makes them odd
// R24 - zero parity sends 0 and ignores the received parity
// R25 - power off resets port, status, shift and buffer; input high
// R26 - clearing an enable resets its own circuit
// R27 - select 11 chooses divide by 32
// R28 - after start, sample each bit every 2k base clocks mid-bit
`timescale 1ns/1ps
`include "asp_consts.svh"
module asp_top (
  input  wire logic        REF_CLK_I,
  input  wire logic        RST_I,
  input  wire logic        CYC_I,
  input  wire logic        STB_I,
  input  wire logic        WE_I,
  input  wire logic [4:0]  ADR_I,
  input  wire logic [3:0]  SEL_I,
  input  wire logic [31:0] DAT_I,
  input  wire logic        SERIAL_IN_PIN_I,
  input  wire logic        EXTERNAL_TIMER_OUTPUT_I,
  output logic      [31:0] DAT_O,
  output logic             ACK_O,
  output logic             SERIAL_OUT_PIN_O,
  output logic             TRANSMIT_DONE_IRQ_O,
  output logic             RECEIVE_IRQ_O
);

  // ==========================================================
  // shared helpers
  function automatic logic [3:0] data_len(input asp_pkg::asp_mode_type m);
    return m.len8 ? 4'h8 : 4'h7;
  endfunction : data_len

  function automatic logic has_par(input asp_pkg::asp_mode_type m);
    return m.parity != asp_pkg::ASP_PAR_NONE;
  endfunction : has_par

  function automatic logic par_calc(input logic [7:0] d,
                                    input asp_pkg::asp_mode_type m);
    logic [7:0] dm;
    dm = m.len8 ? d : {1'b0, d[6:0]};
    case (m.parity)
      asp_pkg::ASP_PAR_ODD:  par_calc = ~^dm;
      asp_pkg::ASP_PAR_EVEN: par_calc = ^dm;
      default:               par_calc = 1'b0;
    endcase
  endfunction : par_calc

  function automatic logic [11:0] build_frame(input logic [7:0] d,
                                              input asp_pkg::asp_mode_type m);
    logic [11:0] f;
    logic [3:0]  n;
    f    = 12'hFFF;
    n    = data_len(m);
    f[0] = 1'b0;
    for (int i = 0; i < 8; i++) begin
      if (i < int'(n)) begin
        f[i+1] = d[i];
      end
    end
    if (has_par(m)) begin
      f[n+4'h1] = par_calc(d, m);
    end
    return f;
  endfunction : build_frame

  // ==========================================================
  // bus decode, one-cycle registered answer
  logic       req;
  logic       wr;
  logic       rd;
  logic [2:0] idx;
  assign req = CYC_I & STB_I & ~ACK_O;
  assign idx = ADR_I[4:2];
  assign wr  = req & WE_I & SEL_I[0];
  assign rd  = req & ~WE_I;

  asp_pkg::asp_mode_type     mode_reg;
  asp_pkg::asp_mode_type     mode_wr;
  asp_pkg::asp_brg_type      brg_reg;
  asp_pkg::asp_err_type      err_reg;
  asp_pkg::asp_tx_state_type tx_state_reg;
  asp_pkg::asp_rx_state_type rx_state_reg;
  logic [7:0] txs_reg;
  logic [7:0] rxb_reg;
  logic       rx_full_reg;
  logic       err_rd;
  logic       rxb_rd;
  logic       power;
  assign power  = mode_reg.power;
  assign err_rd = rd && (idx == `ASP_IDX_ERR);
  assign rxb_rd = rd && (idx == `ASP_IDX_RXB);

  // ack and read data
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      ACK_O <= 1'b0;
      DAT_O <= '0;
    end else begin
      ACK_O <= req;
      DAT_O <= '0;
      if (rd) begin
        case (idx)
          `ASP_IDX_MODE: DAT_O[7:0] <= mode_reg;
          `ASP_IDX_ERR:  DAT_O[2:0] <= err_reg;
          `ASP_IDX_BRG:  DAT_O[7:0] <= brg_reg;
          `ASP_IDX_TXS:  DAT_O[7:0] <= txs_reg;
          `ASP_IDX_RXB:  DAT_O[7:0] <= rxb_reg;
          `ASP_IDX_STAT: DAT_O[1:0] <= {rx_full_reg, tx_state_reg == asp_pkg::TX_SEND};
          default:       DAT_O      <= '0; // unmapped reads zero
        endcase
      end
    end
  end

  // R2 enable order
  // enables stick only if power was already on
  always_comb begin
    mode_wr        = asp_pkg::asp_mode_type'(DAT_I[7:0]);
    mode_wr.txen   = mode_wr.txen & mode_wr.power & mode_reg.power;
    mode_wr.rxen   = mode_wr.rxen & mode_wr.power & mode_reg.power;
    mode_wr.fixed1 = 1'b1;
  end

  // mode and baud control registers
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      mode_reg <= asp_pkg::asp_mode_type'(`ASP_MODE_RST);
      brg_reg  <= asp_pkg::asp_brg_type'(`ASP_BRG_RST);
    end else if (wr) begin
      if (idx == `ASP_IDX_MODE) begin
        mode_reg <= mode_wr;
      end
      if (idx == `ASP_IDX_BRG) begin
        brg_reg      <= asp_pkg::asp_brg_type'(DAT_I[7:0]);
        brg_reg.rsvd <= 1'b0;
      end
    end
  end

  // ==========================================================
  // base clock enable
  logic [4:0] pre_cnt_reg;
  logic       tmr_meta_reg;
  logic       tmr_sync_reg;
  logic       tmr_prev_reg;
  logic       base_en;

  // R18 prescaler gated
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I || !power) begin
      pre_cnt_reg <= '0;
    end else begin
      pre_cnt_reg <= pre_cnt_reg + 5'h01;
    end
  end

  // timer output is foreign: two flops, then edge detect
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      tmr_meta_reg <= 1'b0;
      tmr_sync_reg <= 1'b0;
      tmr_prev_reg <= 1'b0;
    end else begin
      tmr_meta_reg <= EXTERNAL_TIMER_OUTPUT_I;
      tmr_sync_reg <= tmr_meta_reg;
      tmr_prev_reg <= tmr_sync_reg;
    end
  end

  // R22 source select
  // R27 fourth code
  always_comb begin
    case (brg_reg.clk_sel)
      2'h0:    base_en = tmr_sync_reg & ~tmr_prev_reg;
      2'h1:    base_en = (pre_cnt_reg & `ASP_DIV2_MASK) == `ASP_DIV2_MASK;
      2'h2:    base_en = (pre_cnt_reg & `ASP_DIV8_MASK) == `ASP_DIV8_MASK;
      default: base_en = (pre_cnt_reg & `ASP_DIV32_MASK) == `ASP_DIV32_MASK;
    endcase
    base_en = base_en & power;
  end

  // ==========================================================
  // transmitter
  logic        tx_run;
  logic        tx_load;
  logic        tx_half;
  logic [4:0]  tx_cnt;
  logic        tx_phase_reg;
  logic        tx_bound;
  logic [11:0] frame_reg;
  logic [3:0]  tx_left_reg;
  assign tx_run   = power & mode_reg.txen;
  assign tx_load  = wr && (idx == `ASP_IDX_TXS) && tx_run && (tx_state_reg == asp_pkg::TX_IDLE);
  assign tx_bound = tx_half & tx_phase_reg;
  assign SERIAL_OUT_PIN_O = frame_reg[0];

  // R17 own counter
  // R19 cleared when off or on write
  asp_brg #(.CNT_W(5)) u_tx_brg (
    .clk_i  (REF_CLK_I),
    .rst_i  (RST_I),
    .clr_i  (~tx_run | tx_load),
    .tick_i (base_en),
    .k_i    (brg_reg.k),
    .half_o (tx_half),
    .cnt_o  (tx_cnt)
  );

  // R21 two halves of k make one bit
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I || !tx_run || tx_load) begin
      tx_phase_reg <= 1'b0;
    end else if (tx_half) begin
      tx_phase_reg <= ~tx_phase_reg;
    end
  end

  // R3 frame shift-out
  // R5 ones fill in behind
  // R26 transmit circuit reset
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I || !tx_run) begin
      tx_state_reg        <= asp_pkg::TX_IDLE;
      frame_reg           <= 12'hFFF;
      tx_left_reg         <= 4'h0;
      TRANSMIT_DONE_IRQ_O <= 1'b0;
    end else begin
      TRANSMIT_DONE_IRQ_O <= 1'b0;
      if (tx_load) begin
        // R1 no parity slot
        frame_reg    <= build_frame(DAT_I[7:0], mode_reg);
        tx_left_reg  <= 4'h1 + data_len(mode_reg) + {3'h0, has_par(mode_reg)}
                        + (mode_reg.stop2 ? 4'h2 : 4'h1);
        tx_state_reg <= asp_pkg::TX_SEND;
      end else if (tx_state_reg == asp_pkg::TX_SEND && tx_bound) begin
        frame_reg   <= {1'b1, frame_reg[11:1]};
        tx_left_reg <= tx_left_reg - 4'h1;
        // R4 done after last stop
        if (tx_left_reg == 4'h1) begin
          tx_state_reg        <= asp_pkg::TX_IDLE;
          TRANSMIT_DONE_IRQ_O <= 1'b1;
        end
      end
    end
  end

  // R25 shift register cleared by power off
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I || !power) begin
      txs_reg <= `ASP_DATA_RST;
    end else if (tx_load) begin
      txs_reg <= DAT_I[7:0];
    end
  end

  // ==========================================================
  // receive input: sync, then match filter
  logic rx_meta_reg;
  logic rx_sync_reg;
  logic rx_in;
  logic samp_reg;
  logic filt_reg;
  logic filt_prev_reg;

  // two flops; pin reads high while power off
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      rx_meta_reg <= 1'b1;
      rx_sync_reg <= 1'b1;
    end else begin
      rx_meta_reg <= SERIAL_IN_PIN_I;
      rx_sync_reg <= rx_meta_reg;
    end
  end
  // R25 input forced high
  assign rx_in = power ? rx_sync_reg : 1'b1;

  // R16 two equal samples
  // glitches shorter than one base tick never reach the receiver
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I || !power) begin
      samp_reg      <= 1'b1;
      filt_reg      <= 1'b1;
      filt_prev_reg <= 1'b1;
    end else begin
      filt_prev_reg <= filt_reg;
      if (base_en) begin
        samp_reg <= rx_in;
        if (samp_reg == rx_in) begin
          filt_reg <= rx_in;
        end
      end
    end
  end

  // ==========================================================
  // receiver
  logic       rx_en;
  logic       rx_half;
  logic [4:0] rx_cnt;
  logic       rx_phase_reg;
  logic [3:0] rx_idx_reg;
  logic [9:0] rx_bits_reg; // room for the stop slot of the longest frame
  logic [3:0] rx_total;
  logic       rx_done;
  logic [7:0] rx_data;
  logic       rx_perr;
  logic       rx_ferr;
  logic       rx_ovr;
  assign rx_en = power & mode_reg.rxen;
  // R11 single stop bit
  assign rx_total = data_len(mode_reg) + {3'h0, has_par(mode_reg)} + 4'h1;
  assign rx_done  = (rx_state_reg == asp_pkg::RX_BITS) && rx_half && rx_phase_reg
                    && (rx_idx_reg == rx_total - 4'h1);
  assign rx_data  = mode_reg.len8 ? rx_bits_reg[7:0] : {1'b0, rx_bits_reg[6:0]};
  // R14 error causes
  // R23 odd and even check
  // R24 zero parity ignored
  assign rx_perr  = (mode_reg.parity == asp_pkg::ASP_PAR_ODD
                     || mode_reg.parity == asp_pkg::ASP_PAR_EVEN)
                    && (par_calc(rx_data, mode_reg) != rx_bits_reg[data_len(mode_reg)]);
  assign rx_ferr  = ~filt_reg;
  // a read in the same cycle empties the buffer first
  assign rx_ovr   = rx_full_reg & ~rxb_rd;

  // R20 counter runs only in a frame
  // R17 own counter
  asp_brg #(.CNT_W(5)) u_rx_brg (
    .clk_i  (REF_CLK_I),
    .rst_i  (RST_I),
    .clr_i  (~rx_en | (rx_state_reg == asp_pkg::RX_IDLE)),
    .tick_i (base_en),
    .k_i    (brg_reg.k),
    .half_o (rx_half),
    .cnt_o  (rx_cnt)
  );

  // R28 phase restarts at start centre
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I || rx_state_reg != asp_pkg::RX_BITS) begin
      rx_phase_reg <= 1'b0;
    end else if (rx_half) begin
      rx_phase_reg <= ~rx_phase_reg;
    end
  end

  // R7 only when enabled
  // R26 receive circuit reset
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I || !rx_en) begin
      rx_state_reg <= asp_pkg::RX_IDLE;
      rx_idx_reg   <= 4'h0;
      rx_bits_reg  <= '0;
    end else begin
      case (rx_state_reg)
        asp_pkg::RX_IDLE: begin
          if (filt_prev_reg && !filt_reg) begin
            rx_state_reg <= asp_pkg::RX_START;
          end
        end
        // R8 resample after k
        asp_pkg::RX_START: begin
          if (rx_half) begin
            rx_idx_reg   <= 4'h0;
            rx_state_reg <= filt_reg ? asp_pkg::RX_IDLE : asp_pkg::RX_BITS;
          end
        end
        // R9 shift in at baud rate
        asp_pkg::RX_BITS: begin
          if (rx_half && rx_phase_reg) begin
            rx_bits_reg[rx_idx_reg] <= filt_reg;
            rx_idx_reg              <= rx_idx_reg + 4'h1;
            if (rx_done) begin
              rx_state_reg <= asp_pkg::RX_IDLE;
            end
          end
        end
        default: rx_state_reg <= asp_pkg::RX_IDLE;
      endcase
    end
  end

  // R10 pulse at stop position
  // R12 pulse on completion or error
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I || !rx_en) begin
      RECEIVE_IRQ_O <= 1'b0;
    end else begin
      RECEIVE_IRQ_O <= rx_done;
    end
  end

  // R9 buffer kept on overrun
  // R25 buffer cleared by power off
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I || !power) begin
      rxb_reg     <= `ASP_DATA_RST;
      rx_full_reg <= 1'b0;
    end else begin
      if (rx_done && !rx_ovr) begin
        rxb_reg <= rx_data;
      end
      rx_full_reg <= (rx_full_reg & ~rxb_rd) | rx_done;
    end
  end

  // R13 read clears, new error wins
  // R1 parity flag never set without parity
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I || !power) begin
      err_reg <= '0;
    end else begin
      err_reg <= (err_rd ? 3'h0 : err_reg)
                 | (rx_done ? {rx_perr, rx_ferr, rx_ovr} : 3'h0);
    end
  end

  // ==========================================================
  // assertions
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (RST_I);

  AST_TX_IDLE_MARK: assert property ( // R5
    tx_state_reg == asp_pkg::TX_IDLE |-> SERIAL_OUT_PIN_O)
    else $error("idle transmit line not high");
  AST_TX_START_BIT: assert property ( // R3
    tx_load |=> !SERIAL_OUT_PIN_O && tx_state_reg == asp_pkg::TX_SEND)
    else $error("no start bit after write");
  AST_TX_DONE_IDLE: assert property ( // R4
    $rose(TRANSMIT_DONE_IRQ_O) |-> $past(tx_bound) && tx_state_reg == asp_pkg::TX_IDLE
    ##1 !TRANSMIT_DONE_IRQ_O)
    else $error("transmit done pulse misplaced");
  AST_BASE_GATED: assert property ( // R18
    !power |-> !base_en)
    else $error("base clock runs while power off");
  AST_TX_CNT_HELD: assert property ( // R19
    !tx_run || tx_load |=> tx_cnt == 5'h00)
    else $error("transmit counter not held at zero");
  AST_ERR_RD_CLEAR: assert property ( // R13
    err_rd && !rx_done |=> err_reg == 3'h0)
    else $error("error status not cleared by read");
  AST_NO_PAR_ERR: assert property ( // R1
    rx_done && !has_par(mode_reg) && (err_rd || !err_reg.pe) |=> !err_reg.pe)
    else $error("parity error without parity");
  AST_OVR_KEEPS_BUF: assert property ( // R9
    rx_done && rx_ovr |=> $stable(rxb_reg) && err_reg.ove && RECEIVE_IRQ_O)
    else $error("overrun overwrote buffer");
  AST_RX_OFF_IDLE: assert property ( // R7
    !rx_en |=> rx_state_reg == asp_pkg::RX_IDLE && rx_cnt == 5'h00)
    else $error("receiver active while disabled");
  AST_FALSE_START: assert property ( // R8
    rx_state_reg == asp_pkg::RX_START && rx_half && filt_reg
    |=> rx_state_reg == asp_pkg::RX_IDLE)
    else $error("high start sample not ignored");

  COV_TX_DONE:  cover property (TRANSMIT_DONE_IRQ_O);
  COV_RX_CLEAN: cover property (rx_done && !rx_perr && !rx_ferr && !rx_ovr);
  COV_RX_OVR:   cover property (rx_done && rx_ovr);
  COV_RX_PERR:  cover property (rx_done && rx_perr);

endmodule : asp_top

// ### testbench/asp_remote_uart.sv
// Purpose: remote serial transceiver facing the port pins
// Assumes: bit time in clocks set by the bench in bit_clks
// Notes:   released line goes to the idle high level
`timescale 1ns/1ps
module asp_remote_uart (
  input  wire logic clk_i,
  input  wire logic line_i,
  output logic      line_o
);
  // ==========================================================
  // state read by the bench
  int          bit_clks = 32;
  int          got      = 0;
  logic [11:0] cap;
  initial line_o = 1'b1;

  // ==========================================================
  // frame sent lsb first
  task automatic send_frame(input logic [11:0] f, input int n);
    for (int i = 0; i < n; i++) begin
      line_o <= f[i];
      repeat (bit_clks) @(posedge clk_i);
    end
    line_o <= 1'b1; // pull-up level once released
    // one idle bit so back-to-back frames never share a time step
    repeat (bit_clks) @(posedge clk_i);
  endtask : send_frame

  // mid-bit capture; twelve slots so idle after stop is seen too
  always begin
    @(negedge line_i);
    repeat (bit_clks / 2) @(posedge clk_i);
    for (int i = 0; i < 12; i++) begin
      cap[i] = line_i;
      if (i < 11) repeat (bit_clks) @(posedge clk_i);
    end
    got++;
  end
endmodule : asp_remote_uart

// ### testbench/async_serial_port_with_brg_tb_top.sv
// Purpose: register-level bench for the serial port
// Assumes: one wait state per bus access, timer select ticks every 4 clocks
// Notes:   expected frames are built here, never read back from the port
`timescale 1ns/1ps
module async_serial_port_with_brg_tb_top;
  // ==========================================================
  // stimulus and bookkeeping
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we  = 1'b0;
  logic [4:0]  adr = '0;
  logic [3:0]  sel = '0;
  logic [31:0] dat = '0;
  logic [1:0]  tmr = '0;
  logic [31:0] rdat;
  logic        ack;
  logic        txd;
  logic        rxd;
  logic        done;
  logic        rirq;
  logic [31:0] rv;
  int          bad_count = 0;
  int          n_checks  = 0;
  int          c;
  int          g;
  int          bits;
  int          bclk;
  logic [7:0]  t_baud [4] = '{8'h5F, 8'h88, 8'hC8, 8'h08};
  logic [7:0]  t_mode [4] = '{8'hE5, 8'hFD, 8'hF3, 8'hED};
  logic [7:0]  t_data [4] = '{8'h87, 8'h55, 8'h36, 8'hFF};
  int          t_tpc  [4] = '{2, 8, 32, 4};
  logic [7:0]  r_data [5] = '{8'h5A, 8'hC3, 8'h11, 8'h01, 8'h02};
  logic [11:0] r_flip [5] = '{12'h000, 12'h200, 12'h400, 12'h000, 12'h200};
  logic [7:0]  r_mode [5] = '{8'hFD, 8'hFD, 8'hFD, 8'hE5, 8'hED};
  logic [2:0]  r_err  [5] = '{3'h0, 3'h4, 3'h2, 3'h0, 3'h1};
  logic [7:0]  r_buf  [5] = '{8'h5A, 8'hC3, 8'h11, 8'h00, 8'h01};

  // clock and a slow timer output for base select 00
  always #10 clk = ~clk;
  always @(posedge clk) tmr <= tmr + 2'h1;

  asp_top uut (
    .REF_CLK_I(clk), .RST_I(rst), .CYC_I(cyc), .STB_I(stb), .WE_I(we),
    .ADR_I(adr), .SEL_I(sel), .DAT_I(dat), .SERIAL_IN_PIN_I(rxd),
    .EXTERNAL_TIMER_OUTPUT_I(tmr[1]), .DAT_O(rdat), .ACK_O(ack),
    .SERIAL_OUT_PIN_O(txd), .TRANSMIT_DONE_IRQ_O(done), .RECEIVE_IRQ_O(rirq)
  );
  asp_remote_uart rem (.clk_i(clk), .line_i(txd), .line_o(rxd));

  // ==========================================================
  // helpers
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : tally_and_finish

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  // classic cycle, held until ack is sampled high
  task automatic wb(input logic w, input logic [4:0] a, input logic [7:0] d,
                    output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    sel <= 4'h1;
    dat <= {24'h0, d};
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
    if (n >= 50) begin
      bad_count++;
      tally_and_finish();
    end
  endtask : wb

  // bounded wait for a one-cycle pulse; rx picks which
  task automatic wait_pulse(input logic rx, output int n);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (((rx ? rirq : done) !== 1'b1) && n < 20000);
    if (n >= 20000) begin
      bad_count++;
      tally_and_finish();
    end
  endtask : wait_pulse

  // line image: start, data lsb first, parity, stops and idle all high
  function automatic logic [11:0] frame(input logic [7:0] d, input logic [7:0] m);
    logic [11:0] f;
    int          n;
    logic        p;
    f    = '1;
    f[0] = 1'b0;
    n    = m[2] ? 8 : 7;
    p    = ^(d & (m[2] ? 8'hFF : 8'h7F));
    for (int i = 0; i < n; i++) f[1+i] = d[i];
    case (m[4:3])
      2'h1: f[1+n] = 1'b0;
      2'h2: f[1+n] = ~p;
      2'h3: f[1+n] = p;
      default: ;
    endcase
    return f;
  endfunction : frame

  // ==========================================================
  // main sequence
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    wb(0, 5'h00, 8'h00, rv);
    check("mode reset", rv, 32'h01);
    wb(0, 5'h08, 8'h00, rv);
    check("baud reset", rv, 32'h08);
    wb(0, 5'h18, 8'h00, rv);
    check("unmapped", rv, 32'h00);
    wb(1, 5'h0C, 8'hA5, rv); // data write while powered down
    wb(0, 5'h14, 8'h00, rv);
    check("busy unpowered", rv, 32'h00);
    check("tx idle", {31'h0, txd}, 32'h1);
    $display("test registers done");
    wb(1, 5'h00, 8'h81, rv); // power first, enables after
    // every select code and parity kind, both data lengths and both stop counts
    for (int i = 0; i < 4; i++) begin
      bits = 1 + (t_mode[i][2] ? 8 : 7) + (t_mode[i][4:3] != 2'h0) + 1 + t_mode[i][1];
      bclk = 2 * int'(t_baud[i][4:0]) * t_tpc[i];
      rem.bit_clks = bclk;
      wb(1, 5'h08, t_baud[i], rv);
      wb(1, 5'h00, t_mode[i], rv);
      g = rem.got;
      wb(1, 5'h0C, t_data[i], rv);
      wait_pulse(1'b0, c); // next write only after done
      check("done time", 32'(c >= bits*bclk - t_tpc[i] - 4 && c <= bits*bclk + t_tpc[i] + 4), 1);
      check("stop level", {31'h0, txd}, 32'h1);
      c = 0;
      while (rem.got == g && c < 4 * bclk) begin
        @(posedge clk);
        c++;
      end
      if (rem.got == g) begin
        bad_count++;
        tally_and_finish();
      end
      check("tx frame", {20'h0, rem.cap}, {20'h0, frame(t_data[i], t_mode[i])});
    end
    $display("test transmit done");
    rem.bit_clks = 32;
    wb(1, 5'h08, 8'h48, rv);
    // good, parity fault, framing fault, then an overrun pair in no and zero parity
    for (int i = 0; i < 5; i++) begin
      wb(1, 5'h00, r_mode[i], rv);
      fork
        rem.send_frame(frame(r_data[i], r_mode[i]) ^ r_flip[i], 11);
        wait_pulse(1'b1, c);
      join
      if (i != 3) begin
        wb(0, 5'h04, 8'h00, rv); // status before buffer
        check("err flags", rv, {29'h0, r_err[i]});
        wb(0, 5'h04, 8'h00, rv);
        check("err cleared", rv, 32'h0);
        wb(0, 5'h10, 8'h00, rv);
        check("rx buffer", rv, {24'h0, r_buf[i]});
      end else begin
        wb(0, 5'h14, 8'h00, rv);
        check("rx full", rv, 32'h2);
      end
    end
    $display("test receive done");
    wb(1, 5'h00, 8'h01, rv);
    wb(0, 5'h04, 8'h00, rv);
    check("err after off", rv, 32'h0);
    wb(0, 5'h10, 8'h00, rv);
    check("rxb after off", rv, 32'h0);
    wb(0, 5'h0C, 8'h00, rv);
    check("txs after off", rv, 32'h0);
    wb(0, 5'h00, 8'h00, rv);
    check("mode after off", rv, 32'h01);
    $display("test power off done");
    tally_and_finish();
  end
endmodule : async_serial_port_with_brg_tb_top
